// ### cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic irq_n,
  input wire logic [3:0] code,
  output logic [3:0] mask_q,
  output logic [3:0] taken_q
);
  // Level zero is always at or below the mask
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= 4'hF;
      taken_q <= 4'h0;
    end else if (!irq_n && code <= mask_q) begin
      taken_q <= code;
      mask_q <= code - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### interrupt_prioritizer_parallel_io.v
`timescale 1ns/100ps
`default_nettype none
`include "prio_io_map.vh"

module interrupt_prioritizer_parallel_io #(
  parameter LINES = 16,
  parameter LEVELS = 15
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire board_reset_n,
  input wire load_request_n,
  input wire [5:1] dedicated_request_n,
  input wire ext_level6_request_n,
  input wire level6_rise_in,
  input wire level6_fall_in,
  input wire serial_bus_clear_pulse,
  input wire io_reset_instruction,
  input wire [LINES-1:0] pio_in,
  output reg [LINES-1:0] pio_out,
  output reg [LINES-1:0] pio_oe,
  output reg irq_to_cpu_n,
  output reg [3:0] priority_level_code,
  output reg cpu_reset_n,
  output reg cpu_load_n,
  output reg int_out
);

  localparam NPIN = LINES + 12;

  // Idle level of every synchronised pin, so no false edge follows reset
  localparam [NPIN-1:0] PIN_IDLE = {{LINES{1'b1}}, 5'h1F, 1'b1, 1'b1,
    1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  // Line state after reset: all inputs, driven value high
  localparam [LINES-1:0] OUT_RST = `PIO_OUT_RESET;
  localparam [LINES-1:0] OE_RST = `PIO_OE_RESET;

  // Lowest pending level number wins
  function [3:0] encode_level;
    input [LEVELS:1] pend;
    integer k;
    begin
      encode_level = `CODE_IDLE;
      for (k = LEVELS; k >= 1; k = k - 1) begin
        if (pend[k]) begin
          encode_level = k[3:0];
        end
      end
    end
  endfunction

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  wire [NPIN-1:0] pins_raw;
  reg [NPIN-1:0] pins_meta_q;
  reg [NPIN-1:0] pins_q;

  assign pins_raw = {pio_in, dedicated_request_n, board_reset_n,
    load_request_n, ext_level6_request_n, level6_rise_in, level6_fall_in,
    serial_bus_clear_pulse, io_reset_instruction};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_meta_q <= PIN_IDLE;
      pins_q <= PIN_IDLE;
    end else begin
      pins_meta_q <= pins_raw;
      pins_q <= pins_meta_q;
    end
  end

  wire [LINES-1:0] pio_s = pins_q[NPIN-1:12];
  wire [5:1] ded_n_s = pins_q[11:7];
  wire board_rst_n_s = pins_q[6];
  wire load_n_s = pins_q[5];
  wire l6_level_n_s = pins_q[4];
  wire rise_s = pins_q[3];
  wire fall_s = pins_q[2];
  wire bus_clear_s = pins_q[1];
  wire io_rst_s = pins_q[0];

  // Delayed copies for edge detection, reset to the idle levels
  reg rise_d1_q;
  reg fall_d1_q;
  reg io_rst_d1_q;
  reg bus_clear_d1_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_d1_q <= 1'b0;
      fall_d1_q <= 1'b1;
      io_rst_d1_q <= 1'b0;
      bus_clear_d1_q <= 1'b0;
    end else begin
      rise_d1_q <= rise_s;
      fall_d1_q <= fall_s;
      io_rst_d1_q <= io_rst_s;
      bus_clear_d1_q <= bus_clear_s;
    end
  end

  wire rise_edge = rise_s & ~rise_d1_q;
  wire fall_edge = ~fall_s & fall_d1_q;
  wire io_rst_edge = io_rst_s & ~io_rst_d1_q;
  wire bus_clear_edge = bus_clear_s & ~bus_clear_d1_q;

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave

  reg [7:0] addr_q;
  reg wr_q;

  // Zero wait states: the data phase always follows in the next cycle
  wire take = hsel & hready & htrans[1];
  wire wr_en = wr_q;
  wire [7:0] a_ph = haddr[7:0];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 8'h00;
      wr_q <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        addr_q <= {a_ph[7:2], 2'b00};
        wr_q <= take & hwrite;
      end
    end
  end

  wire wr_ctrl = wr_en & hit(addr_q, `OFS_CTRL);
  wire wr_mask = wr_en & hit(addr_q, `OFS_MASK);
  wire wr_pio = wr_en & hit(addr_q, `OFS_PIO_BIT);
  wire wr_l6clr = wr_en & hit(addr_q, `OFS_L6_CLEAR);
  wire wr_iclr = wr_en & hit(addr_q, `OFS_INT_CLEAR);
  wire wr_ien = wr_en & hit(addr_q, `OFS_INT_ENABLE);

  ////////////////////////////////////////////////////////////////////////
  // Control, mask and I/O reinitialisation

  reg clock_mode_q;
  reg [LEVELS:1] mask_q;

  // Clock mode already selected, then bit 15 written as zero
  wire soft_init = wr_ctrl & clock_mode_q &
    ~hwdata[`CTRL_REINIT_BIT];
  wire io_init = soft_init | io_rst_edge;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_mode_q <= 1'b0;
      mask_q <= `MASK_RESET;
    end else begin
      if (io_init) begin
        clock_mode_q <= 1'b0;
      end else if (wr_ctrl) begin
        clock_mode_q <= hwdata[`CTRL_CLOCK_MODE];
      end
      if (wr_mask) begin
        mask_q <= hwdata[LEVELS:1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Parallel lines

  wire [3:0] pio_idx = hwdata[`PIO_BIT_IDX_LSB+3:`PIO_BIT_IDX_LSB];

  genvar g;
  generate
    for (g = 0; g < LINES; g = g + 1) begin : line
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pio_out[g] <= OUT_RST[g];
          pio_oe[g] <= OE_RST[g];
        end else if (io_init) begin
          pio_out[g] <= 1'b1;
          pio_oe[g] <= 1'b0;
        end else if (wr_pio && pio_idx == g) begin
          pio_out[g] <= hwdata[`PIO_BIT_VAL];
          pio_oe[g] <= 1'b1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Level 6 edge capture

  reg l6_rise_q;
  reg l6_fall_q;
  wire l6_clear = wr_l6clr | bus_clear_edge;
  // An edge in the same cycle as a clear keeps the request

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      l6_rise_q <= 1'b0;
      l6_fall_q <= 1'b0;
    end else begin
      if (rise_edge) begin
        l6_rise_q <= 1'b1;
      end else if (l6_clear) begin
        l6_rise_q <= 1'b0;
      end
      if (fall_edge) begin
        l6_fall_q <= 1'b1;
      end else if (l6_clear) begin
        l6_fall_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request gathering and encoding

  reg [LEVELS:1] req;
  integer j;

  always @* begin
    req = {LEVELS{1'b0}};
    req[5:1] = ~ded_n_s;
    req[6] = ~l6_level_n_s | l6_rise_q | l6_fall_q;
    for (j = `LEVEL_SHARED_FIRST; j <= `LEVEL_LOWEST; j = j + 1) begin
      req[j] = ~pio_s[`LEVEL_SHARED_FIRST + `LEVEL_LOWEST - j];
    end
  end

  wire [LEVELS:1] pend = req & mask_q;
  wire any_pend = |pend;
  wire [3:0] code = encode_level(pend);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_to_cpu_n <= 1'b1;
      priority_level_code <= `CODE_IDLE;
      cpu_reset_n <= 1'b0;
      cpu_load_n <= 1'b1;
    end else begin
      irq_to_cpu_n <= ~any_pend;
      priority_level_code <= code;
      cpu_reset_n <= board_rst_n_s;
      cpu_load_n <= load_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event status, enable and interrupt output

  reg [`EV_WIDTH-1:0] ev_status_q;
  reg [`EV_WIDTH-1:0] ev_enable_q;
  reg [`EV_WIDTH-1:0] ev_set;

  always @* begin
    ev_set = {`EV_WIDTH{1'b0}};
    ev_set[`EV_L6_EDGE] = rise_edge | fall_edge;
    ev_set[`EV_CPU_REQ] = any_pend & irq_to_cpu_n;
    ev_set[`EV_IO_INIT] = io_init;
  end

  wire [`EV_WIDTH-1:0] ev_clr = wr_iclr ? hwdata[`EV_WIDTH-1:0] :
    {`EV_WIDTH{1'b0}};
  // A new event wins over a clear of the same bit
  wire [`EV_WIDTH-1:0] ev_next = (ev_status_q & ~ev_clr) | ev_set;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_status_q <= {`EV_WIDTH{1'b0}};
      ev_enable_q <= {`EV_WIDTH{1'b0}};
      int_out <= 1'b0;
    end else begin
      ev_status_q <= ev_next;
      if (wr_ien) begin
        ev_enable_q <= hwdata[`EV_WIDTH-1:0];
      end
      int_out <= |(ev_next & (wr_ien ? hwdata[`EV_WIDTH-1:0] :
        ev_enable_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, registered at the address phase

  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case ({a_ph[7:2], 2'b00})
      `OFS_CTRL: begin
        rd_mux[`CTRL_CLOCK_MODE] = clock_mode_q;
      end
      `OFS_MASK: begin
        rd_mux[LEVELS:1] = mask_q;
      end
      `OFS_STATE: begin
        rd_mux[3:0] = priority_level_code;
        rd_mux[4] = ~irq_to_cpu_n;
        rd_mux[5] = l6_rise_q;
        rd_mux[6] = l6_fall_q;
        rd_mux[LEVELS+16:17] = req;
      end
      `OFS_PIO_IN: begin
        rd_mux[LINES-1:0] = pio_s;
      end
      `OFS_PIO_DIR: begin
        rd_mux[LINES-1:0] = pio_oe;
        rd_mux[LINES+15:16] = pio_out;
      end
      `OFS_INT_STATUS: begin
        rd_mux[`EV_WIDTH-1:0] = ev_status_q;
      end
      `OFS_INT_ENABLE: begin
        rd_mux[`EV_WIDTH-1:0] = ev_enable_q;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

endmodule

`default_nettype wire

// ### interrupt_prioritizer_parallel_io_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "prio_io_map.vh"
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t bad value", $time); end end
module interrupt_prioritizer_parallel_io_tb;
  logic hclk = 0, hresetn = 0, hwrite = 0, b_n = 1, ld_n = 1, e6_n = 1;
  logic r6 = 0, f6 = 1, clr = 0, ior = 0, crst = 0;
  logic [1:0] htrans = 0;
  logic [7:0] haddr = 0;
  logic [31:0] hwdata = 0, rd;
  logic [5:1] d_n = 5'h1F;
  logic [15:0] pin = 16'hFFFF;
  wire rdy, rsp, irq_n, c_rst, c_ld, int_out;
  wire [31:0] hrdata;
  wire [15:0] po, oe;
  wire [3:0] code, taken;
  int err_count = 0, total_checks = 0;
  always #2 hclk = ~hclk;
  interrupt_prioritizer_parallel_io DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b1), .haddr({24'h0, haddr}), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy),
    .hresp(rsp), .hrdata(hrdata), .board_reset_n(b_n), .load_request_n(ld_n),
    .dedicated_request_n(d_n), .ext_level6_request_n(e6_n),
    .level6_rise_in(r6), .level6_fall_in(f6), .serial_bus_clear_pulse(clr),
    .io_reset_instruction(ior), .pio_in(pin), .pio_out(po), .pio_oe(oe),
    .irq_to_cpu_n(irq_n), .priority_level_code(code), .cpu_reset_n(c_rst),
    .cpu_load_n(c_ld), .int_out(int_out));
  cpu_model P (.clk(hclk), .rst_n(crst), .irq_n(irq_n), .code(code),
    .mask_q(), .taken_q(taken));
  //////////////////////////////////////////////////////////////////////////
  task bus(input w, input [7:0] a, input [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (!rdy);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (!rdy);
    rd = hrdata;
  endtask
  task st;
    repeat (5) @(posedge hclk);
  endtask
  // Levels 7..15 sit on lines 15..7
  task rq(input int k, input v);
    if (k < 6) d_n[k] <= v;
    else if (k == 6) e6_n <= v;
    else pin[22-k] <= v;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task t_prio;
    int k;
    bus(1, `OFS_MASK, 32'hFFFE);
    crst <= 1;
    st;
    for (k = 15; k > 0; k--) begin
      rq(k, 0);
      st;
      `CHK(code, k[3:0])
      `CHK(irq_n, 1'b0)
      `CHK(taken, k[3:0])
    end
    for (k = 1; k < 16; k++) begin
      rq(k, 1);
      st;
      `CHK(code, k == 15 ? 4'h0 : 4'(k + 1))
    end
    `CHK(irq_n, 1'b1)
    $display("prio done");
  endtask
  task t_mask;
    int k;
    for (k = 1; k < 16; k++) rq(k, 0);
    bus(1, `OFS_MASK, 0);
    st;
    `CHK({irq_n, code}, 5'h10)
    bus(1, `OFS_MASK, 32'h200);
    st;
    `CHK(code, 4'h9)
    bus(0, `OFS_MASK, 0);
    `CHK(rd, 32'h0000_0200)
    b_n <= 0;
    ld_n <= 0;
    st;
    `CHK({c_rst, c_ld}, 2'b00)
    b_n <= 1;
    ld_n <= 1;
    for (k = 1; k < 16; k++) rq(k, 1);
    st;
    $display("mask done");
  endtask
  task t_l6;
    bus(1, `OFS_MASK, 32'h40);
    bus(1, `OFS_INT_ENABLE, 1);
    r6 <= 1;
    st;
    `CHK({code, int_out}, 5'h0D)
    bus(0, `OFS_STATE, 0);
    `CHK(rd, 32'h0040_0036)
    bus(1, `OFS_INT_ENABLE, 0);
    st;
    `CHK(int_out, 1'b0)
    bus(1, `OFS_INT_ENABLE, 1);
    bus(1, `OFS_INT_CLEAR, 1);
    st;
    `CHK(int_out, 1'b0)
    bus(1, `OFS_L6_CLEAR, 0);
    st;
    `CHK(irq_n, 1'b1)
    f6 <= 0;
    st;
    `CHK(code, 4'h6)
    clr <= 1;
    @(posedge hclk);
    clr <= 0;
    st;
    `CHK(irq_n, 1'b1)
    $display("level6 done");
  endtask
  task t_pio;
    bus(0, `OFS_PIO_DIR, 0);
    `CHK(rd, 32'hFFFF0000)
    bus(1, `OFS_PIO_BIT, 32'h003);
    bus(1, `OFS_PIO_BIT, 32'h10F);
    pin[3] <= 1'b0;
    st;
    `CHK({po, oe}, 32'hFFF78008)
    bus(0, `OFS_PIO_IN, 0);
    `CHK(rd[15:0], 16'hFFF7)
    bus(1, `OFS_CTRL, 1);
    bus(0, `OFS_CTRL, 0);
    `CHK(rd, 32'h0000_0001)
    bus(1, `OFS_CTRL, 0);
    st;
    `CHK({po, oe}, 32'hFFFF0000)
    bus(1, `OFS_PIO_BIT, 0);
    ior <= 1;
    st;
    ior <= 0;
    `CHK(oe, 16'h0000)
    bus(0, `OFS_INT_STATUS, 0);
    `CHK(rd, 32'h0000_0007)
    bus(1, `OFS_INT_CLEAR, 32'h0000_0007);
    bus(0, `OFS_INT_STATUS, 0);
    `CHK(rd, 32'h0000_0000)
    bus(0, 8'h40, 0);
    `CHK({rsp, rd}, 33'h0)
    $display("pio done");
  endtask
  task test_done;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    t_prio;
    t_mask;
    t_l6;
    t_pio;
    test_done;
  end
  initial begin
    repeat (5000) @(posedge hclk);
    err_count++;
    test_done;
  end
endmodule
`default_nettype wire

// ### prio_io_map.vh
`ifndef PRIO_IO_MAP_VH
`define PRIO_IO_MAP_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_MASK 8'h04
`define OFS_STATE 8'h08
`define OFS_PIO_BIT 8'h0C
`define OFS_PIO_IN 8'h10
`define OFS_PIO_DIR 8'h14
`define OFS_L6_CLEAR 8'h18
`define OFS_INT_STATUS 8'h1C
`define OFS_INT_CLEAR 8'h20
`define OFS_INT_ENABLE 8'h24

// Level-6 clear location in the bit-serial space, and its base register
`define L6_CLEAR_BIT_ADDR 16'h00A6
`define L6_CLEAR_BASE_REG 16'h014C

// Control register fields
`define CTRL_CLOCK_MODE 0
`define CTRL_REINIT_BIT 15

// Single-bit parallel write fields
`define PIO_BIT_IDX_LSB 0
`define PIO_BIT_VAL 8

// Interrupt event positions
`define EV_L6_EDGE 0
`define EV_CPU_REQ 1
`define EV_IO_INIT 2
`define EV_WIDTH 3

// Reset values
`define MASK_RESET 15'h0000
`define PIO_OUT_RESET 16'hFFFF
`define PIO_OE_RESET 16'h0000

// Priority levels
`define LEVEL_SHARED_FIRST 7
`define LEVEL_LOWEST 15
`define CODE_IDLE 4'h0

`endif

// ### prio_io_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module prio_io_monitor #(
  parameter LINES = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic board_reset_n,
  input wire logic load_request_n,
  input wire logic io_reset_instruction,
  input wire logic [LINES-1:0] pio_out,
  input wire logic [LINES-1:0] pio_oe,
  input wire logic irq_to_cpu_n,
  input wire logic [3:0] priority_level_code,
  input wire logic cpu_reset_n,
  input wire logic cpu_load_n,
  input wire logic int_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_q;
  // Marks the data phase of a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_q <= 1'b0;
    else wr_q <= hsel && hready && htrans[1] && hwrite;
  end
  //////////////////////////////////////////////////////////////////////////
  a_idle_code: assert property (irq_to_cpu_n |-> priority_level_code == 0)
    else $error("code not zero while idle");
  a_req_code: assert property (!irq_to_cpu_n |-> priority_level_code != 0)
    else $error("request with zero code");
  a_reset_low: assert property ((!board_reset_n)[*5] |-> !cpu_reset_n)
    else $error("reset not passed");
  a_reset_high: assert property (board_reset_n[*5] |-> cpu_reset_n)
    else $error("reset stuck");
  a_load_follow: assert property ((load_request_n == 0)[*5] |-> !cpu_load_n)
    else $error("load not passed");
  a_load_idle: assert property (load_request_n[*5] |-> cpu_load_n)
    else $error("load stuck");
  a_io_reinit: assert property ($rose(io_reset_instruction) |->
    ##[2:5] (pio_oe == 0 && pio_out == '1))
    else $error("no reinit");
  a_oe_set: assert property (|(pio_oe & ~$past(pio_oe)) |-> $past(wr_q))
    else $error("line became output unasked");
  a_out_hold: assert property ($changed(pio_out) |->
    $past(wr_q) || pio_out == '1)
    else $error("output line moved");
  c_req: cover property ($fell(irq_to_cpu_n));
  c_low: cover property (priority_level_code == 4'hF);
  c_int: cover property ($rose(int_out));
endmodule
bind interrupt_prioritizer_parallel_io prio_io_monitor #(.LINES(LINES)) mon (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .board_reset_n,
  .load_request_n, .io_reset_instruction, .pio_out, .pio_oe, .irq_to_cpu_n,
  .priority_level_code, .cpu_reset_n, .cpu_load_n, .int_out);
`default_nettype wire
